//--- verilog/psau_params.svh
`ifndef PSAU_PARAMS_SVH
`define PSAU_PARAMS_SVH
// register byte offsets
`define OFF_CORE_CONTROL      8'h00
`define OFF_TABLE_PAGE        8'h04
`define OFF_WINDOW_PAGE       8'h08
`define OFF_ADDR_STATUS       8'h0c
`define OFF_READ_DATA         8'h10
`define OFF_EXTRA_CYCLES      8'h14
// field positions
`define BIT_WINDOW_ENABLE     2
`define BIT_TABLE_CFG         7
`define BIT_EA_MSB            15
`define BIT_PADDR_TOP         23
// reset values
`define RST_CORE_CONTROL      16'h0000
`define RST_TABLE_PAGE        8'h00
`define RST_WINDOW_PAGE       8'h00
// user range limit and step
`define USER_ADDR_MAX         24'h7ffffe
`define PADDR_STEP            23'd2
`endif

//--- verilog/psau_pkg.sv
package psau_pkg;
  typedef enum logic [2:0] {
    acc_fetch,
    acc_data,
    acc_table_read_low,
    acc_table_read_high,
    acc_table_write_low,
    acc_table_write_high
  } access_kind_t;
  typedef enum logic [1:0] {
    cls_move,
    cls_double_move,
    cls_mac_prefetch,
    cls_other
  } instr_class_t;
endpackage

//--- verilog/program_space_access_unit.sv
// Function
// - program space of 4M words reached by PC, table address or window.
// - program address advances by two per 24-bit program word.
// - non-table accesses confined to 0x000000..0x7fffff; 0x7ffffe is the last user word.
// - table page bit 7 picks user (0) or configuration (1) space.
// - address bit 23 set only by table accesses, else zero.
// - table address is table page above the 16-bit data address.
// - window address low 15 bits come from data address low 15 bits.
// - window page register gives program address bits 22:15.
// - low table read returns P15:0, bytes by byte select.
// - high table read returns P23:16 in low byte, zero above; an odd byte-mode read returns zero.
// - window used only when EA msb and window enable both set.
// - upper 32 KB of data maps onto any 16K-word program page.
// - window mapping suspended during table read or write.
// - outside repeat, window adds one cycle for mac/move/double move, else two.
// - inside repeat, two extra on first/last/irq exit/re-entry, else none.
// - window access adds up to two cycles for its program fetches.
`timescale 1ns/1ps
`include "psau_params.svh"
module program_space_access_unit
  import psau_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // access request from execution unit
  input  wire logic        req_valid,
  input  access_kind_t     req_kind,
  input  instr_class_t     req_class,
  input  wire logic [22:0] pc,
  input  wire logic [15:0] data_ea,
  input  wire logic        byte_mode,
  input  wire logic        in_repeat,
  input  wire logic        repeat_first,
  input  wire logic        repeat_last,
  input  wire logic        repeat_irq_exit,
  input  wire logic        repeat_irq_reentry,
  // program memory read data
  input  wire logic [23:0] pmem_rdata,
  // results
  output logic [23:0]      pmem_addr,
  output logic             pmem_en,
  output logic             pmem_we,
  output logic             dmem_en,
  output logic [15:0]      read_data,
  output logic [1:0]       extra_cycles,
  output logic             addr_fault
);

  logic [15:0] core_control_q;
  logic [7:0]  table_page_q;
  logic [7:0]  program_window_page_q;
  logic [23:0] addr_d;
  logic        is_table;
  logic        is_table_read;
  logic        window_hit;
  logic        pmem_hit;
  logic [1:0]  extra_d;
  logic [15:0] rdata_d;

  // byte lane merge for 32-bit bus writes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign is_table      = (req_kind != acc_fetch) && (req_kind != acc_data);
  assign is_table_read = (req_kind == acc_table_read_low) ||
                         (req_kind == acc_table_read_high);
  assign window_hit = (req_kind == acc_data) && data_ea[`BIT_EA_MSB] &&
                      core_control_q[`BIT_WINDOW_ENABLE];
  assign pmem_hit   = window_hit || is_table || (req_kind == acc_fetch);

  // address construction
  always_comb
  begin
    addr_d = 24'h000000;
    case (req_kind)
      acc_fetch:
      begin
        addr_d = {1'b0, pc[22:1], 1'b0};
      end
      acc_data:
      begin
        addr_d = {1'b0, program_window_page_q, data_ea[14:0]};
      end
      acc_table_read_low, acc_table_read_high,
      acc_table_write_low, acc_table_write_high:
      begin
        addr_d = {table_page_q, data_ea};
      end
      default:
      begin
        addr_d = 24'h000000;
      end
    endcase
    if (!is_table)
    begin
      addr_d[`BIT_PADDR_TOP] = 1'b0;
    end
  end

  // extra cycle cost
  always_comb
  begin
    extra_d = 2'd0;
    if (window_hit)
    begin
      if (in_repeat)
      begin
        if (repeat_first || repeat_last || repeat_irq_exit || repeat_irq_reentry)
        begin
          extra_d = 2'd2;
        end
        else
        begin
          extra_d = 2'd0;
        end
      end
      else if (req_class == cls_other)
      begin
        extra_d = 2'd2;
      end
      else
      begin
        extra_d = 2'd1;
      end
    end
  end

  // read data steering
  always_comb
  begin
    rdata_d = 16'h0000;
    case (req_kind)
      acc_table_read_low:
      begin
        rdata_d = !byte_mode ? pmem_rdata[15:0] :
                  {8'h00, (data_ea[0] ? pmem_rdata[15:8] : pmem_rdata[7:0])};
      end
      acc_table_read_high:
      begin
        rdata_d = (byte_mode && data_ea[0]) ? 16'h0000 : {8'h00, pmem_rdata[23:16]};
      end
      acc_data:
      begin
        rdata_d = pmem_rdata[15:0];
      end
      default:
      begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // access outputs
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pmem_addr    <= 24'h000000;
      pmem_en      <= 1'b0;
      pmem_we      <= 1'b0;
      dmem_en      <= 1'b0;
      read_data    <= 16'h0000;
      extra_cycles <= 2'd0;
      addr_fault   <= 1'b0;
    end
    else
    begin
      pmem_addr    <= addr_d;
      pmem_en      <= req_valid && pmem_hit;
      pmem_we      <= req_valid && is_table && !is_table_read;
      dmem_en      <= req_valid && (req_kind == acc_data) && !window_hit;
      read_data    <= rdata_d;
      extra_cycles <= req_valid ? extra_d : 2'd0;
      // odd window byte addresses still lie inside the last user word
      addr_fault   <= req_valid && !is_table && ({addr_d[23:1], 1'b0} > `USER_ADDR_MAX);
    end
  end

  // axi write channel
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == `OFF_CORE_CONTROL ||
                         aw_addr_q == `OFF_TABLE_PAGE ||
                         aw_addr_q == `OFF_WINDOW_PAGE) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      core_control_q        <= `RST_CORE_CONTROL;
      table_page_q          <= `RST_TABLE_PAGE;
      program_window_page_q <= `RST_WINDOW_PAGE;
    end
    else if (do_write)
    begin
      if (aw_addr_q == `OFF_CORE_CONTROL)
      begin
        core_control_q <= merge16(core_control_q, w_data_q, w_strb_q);
      end
      if (aw_addr_q == `OFF_TABLE_PAGE && w_strb_q[0])
      begin
        table_page_q <= w_data_q[7:0];
      end
      if (aw_addr_q == `OFF_WINDOW_PAGE && w_strb_q[0])
      begin
        program_window_page_q <= w_data_q[7:0];
      end
    end
  end

  // axi read channel
  logic [31:0] rd_mux;
  logic        rd_ok;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_ok  = 1'b1;
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      `OFF_CORE_CONTROL: rd_mux = {16'h0000, core_control_q};
      `OFF_TABLE_PAGE:   rd_mux = {24'h000000, table_page_q};
      `OFF_WINDOW_PAGE:  rd_mux = {24'h000000, program_window_page_q};
      `OFF_ADDR_STATUS:  rd_mux = {7'h00, addr_fault, pmem_addr};
      `OFF_READ_DATA:    rd_mux = {16'h0000, read_data};
      `OFF_EXTRA_CYCLES: rd_mux = {29'h0, dmem_en, extra_cycles};
      default:           rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- test/psau_checker.sv
`timescale 1ns/1ps
module psau_checker
  import psau_pkg::*;
(
  // watched ports
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        req_valid,
  input access_kind_t     req_kind,
  input wire logic [22:0] pc,
  input wire logic [15:0] data_ea,
  input wire logic        byte_mode,
  input wire logic [23:0] pmem_rdata,
  input wire logic [23:0] pmem_addr,
  input wire logic        pmem_en,
  input wire logic        dmem_en,
  input wire logic [15:0] read_data,
  input wire logic [1:0]  extra_cycles
);
  logic [22:0] pc_q;
  logic [15:0] ea_q;
  logic [23:0] rd_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge core_clk)
  begin
    pc_q <= pc;
    ea_q <= data_ea;
    rd_q <= pmem_rdata;
  end
  sequence s_upper;
    req_valid && req_kind == acc_data && data_ea[15];
  endsequence
  a_fetch_addr: assert property (req_valid && req_kind == acc_fetch |=>
    pmem_en && pmem_addr == {1'b0, pc_q[22:1], 1'b0}) else $error("fetch address");
  a_table_addr: assert property (req_valid && req_kind > acc_data |=>
    pmem_en && !dmem_en && pmem_addr[15:0] == ea_q) else $error("table address");
  a_no_top_bit: assert property (req_valid && req_kind <= acc_data |=>
    !pmem_addr[23]) else $error("bit 23 set");
  a_one_target: assert property (s_upper |=> pmem_en != dmem_en) else $error("target");
  a_low_data: assert property (req_valid && req_kind == acc_data && !data_ea[15] |=>
    dmem_en && !pmem_en && extra_cycles == 2'h0) else $error("low data");
  a_win_addr: assert property (s_upper ##1 pmem_en |->
    pmem_addr[14:0] == ea_q[14:0]) else $error("window address");
  a_read_high: assert property (
    req_valid && !byte_mode && req_kind == acc_table_read_high |=>
    read_data == {8'h00, rd_q[23:16]}) else $error("high read");
  a_read_low: assert property (
    req_valid && !byte_mode && req_kind == acc_table_read_low |=>
    read_data == rd_q[15:0]) else $error("low read");
endmodule
bind program_space_access_unit psau_checker i_psau_checker (.*);

//--- test/prog_mem_model.sv
`timescale 1ns/1ps
module prog_mem_model
(
  // memory side
  input  wire logic        core_clk,
  input  wire logic [23:0] pmem_addr,
  input  wire logic        pmem_en,
  input  wire logic        pmem_we,
  input  wire logic [23:0] fill,
  output logic [23:0]      pmem_rdata,
  output logic [23:0]      wr_addr_q
);
  assign pmem_rdata = fill;
  always_ff @(posedge core_clk)
  begin
    if (pmem_en && pmem_we)
    begin
      wr_addr_q <= pmem_addr;
    end
  end
endmodule

//--- test/program_space_access_unit_tb_top.sv
`timescale 1ns/1ps
module program_space_access_unit_tb_top
  import psau_pkg::*;
;
  logic core_clk = 0, reset_n = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pmem_en, pmem_we, dmem_en, addr_fault;
  logic [1:0] s_axi_bresp, s_axi_rresp, extra_cycles;
  logic req_valid = 0, byte_mode = 0, in_repeat = 0, repeat_first = 0, repeat_last = 0;
  logic repeat_irq_exit = 0, repeat_irq_reentry = 0;
  access_kind_t req_kind = acc_fetch;
  instr_class_t req_class = cls_move;
  logic [22:0] pc = 0;
  logic [15:0] data_ea = 0, read_data;
  logic [23:0] pmem_rdata, pmem_addr, wr_addr_q, fill = 0;
  int fail_count = 0, compares = 0, cyc = 0;

  program_space_access_unit i_program_space_access_unit (.*);
  prog_mem_model i_prog_mem_model (.*);

  always #4 core_clk = ~core_clk;

  task automatic close_out;
  begin
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, g);
  begin
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  end
  endtask

  // one register cycle, write or read
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e,
                     input logic [1:0] r);
    logic ta, tw, tb;
    logic [33:0] v;
  begin
    @(posedge core_clk);
    tb = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    while (!tb)
    begin
      @(negedge core_clk);
      ta = w ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      tb = w ? s_axi_bvalid : s_axi_rvalid;
      // while a write answer stands both write readies must be low
      v = w ? {s_axi_bresp, 30'h0, s_axi_awready, s_axi_wready} : {s_axi_rresp, s_axi_rdata};
      @(posedge core_clk);
      if (ta)
        {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (tw)
        s_axi_wvalid <= 0;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk("data", e, v[31:0]);
    chk("resp", r, v[33:32]);
  end
  endtask

  // one access, outputs checked after the answering edge
  task automatic acc(input access_kind_t k, input instr_class_t c, input logic [15:0] ea,
                     input logic bm, input logic [4:0] rp);
  begin
    @(posedge core_clk);
    req_valid <= 1;
    req_kind <= k;
    req_class <= c;
    data_ea <= ea;
    byte_mode <= bm;
    {in_repeat, repeat_first, repeat_last, repeat_irq_exit, repeat_irq_reentry} <= rp;
    @(posedge core_clk);
    req_valid <= 0;
    #1;
  end
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1;
    bus(0, 8'h00, 0, 0, 0);
    bus(0, 8'h04, 0, 0, 0);
    bus(0, 8'h08, 0, 0, 0);
    bus(0, 8'h1c, 0, 0, 2'h2);
    bus(1, 8'h10, 1, 0, 2'h2);
    bus(1, 8'h04, 32'h85, 0, 0);
    bus(1, 8'h08, 32'h3c, 0, 0);
    bus(1, 8'h00, 32'h4, 0, 0);
    bus(0, 8'h08, 0, 32'h3c, 0);
    fill <= 24'habcdef;
    pc <= 23'h2468b;
    acc(acc_fetch, cls_other, 16'h8002, 0, 0);
    chk("fetch", 24'h2468a, pmem_addr);
    bus(0, 8'h0c, 0, 32'h2468a, 0);
    acc(acc_table_read_low, cls_other, 16'h1234, 0, 0);
    chk("tbl", 24'h851234, pmem_addr);
    chk("rdl", 16'hcdef, read_data);
    bus(0, 8'h10, 0, 32'hcdef, 0);
    acc(acc_table_read_low, cls_other, 16'h1234, 1, 0);
    chk("rdl0", 8'hef, read_data[7:0]);
    acc(acc_table_read_low, cls_other, 16'h1235, 1, 0);
    chk("rdl1", 8'hcd, read_data[7:0]);
    acc(acc_table_read_high, cls_other, 16'h1234, 0, 0);
    chk("rdh", 16'h00ab, read_data);
    acc(acc_table_read_high, cls_other, 16'h1234, 1, 0);
    chk("rdh0", 8'hab, read_data[7:0]);
    acc(acc_table_read_high, cls_other, 16'h1235, 1, 0);
    chk("rdh1", 8'h00, read_data[7:0]);
    acc(acc_table_write_high, cls_move, 16'h8002, 0, 0);
    chk("twa", 24'h858002, pmem_addr);
    chk("twe", 2'h2, {pmem_we, dmem_en});
    bus(1, 8'h04, 32'h05, 0, 0);
    fill <= 24'hff1357;
    acc(acc_table_write_low, cls_move, 16'h0010, 0, 0);
    chk("twl", 24'h050010, pmem_addr);
    chk("pmw", 24'h858002, wr_addr_q);
    for (int i = 0; i < 4; i++)
    begin
      acc(acc_data, instr_class_t'(i), 16'h8000 + 16'(i * 'h2aaa), 0, 0);
      chk("wext", (i == 3) ? 2 : 1, extra_cycles);
      chk("wadr", 24'h1e0000 + 24'(i * 'h2aaa), pmem_addr);
      chk("wrd", 16'h1357, read_data);
    end
    for (int i = 0; i < 5; i++)
    begin
      acc(acc_data, cls_move, 16'h8004, 0, 5'h10 | (5'h10 >> i));
      chk("rext", (i == 0) ? 0 : 2, extra_cycles);
    end
    bus(1, 8'h08, 32'hff, 0, 0);
    pc <= 23'h7fffff;
    acc(acc_data, cls_move, 16'hffff, 0, 0);
    chk("wtop", {24'h7fffff, 1'b0}, {pmem_addr, addr_fault});
    acc(acc_fetch, cls_move, 16'h0000, 0, 0);
    chk("ftop", {24'h7ffffe, 1'b0}, {pmem_addr, addr_fault});
    acc(acc_data, cls_other, 16'h0040, 0, 0);
    chk("dlow", 3'h4, {dmem_en, extra_cycles});
    bus(1, 8'h00, 0, 0, 0);
    acc(acc_data, cls_other, 16'h8004, 0, 0);
    chk("doff", 4'h8, {dmem_en, pmem_en, extra_cycles});
    close_out();
  end
endmodule
